// [hdl/acmc_pkg.sv]
/*
 Constants for the converter mode control block: register address,
 bit positions, reset value and state codes.
 Assumes the core bus and converter sit on the same clock.
*/
package acmc_pkg;
    // ===========================================================
    // Register map
    localparam logic [7:0] ACMC_ADDR = 8'hD8;
    localparam logic [7:0] ACMC_RESET = 8'h00;
    localparam logic [7:0] ACMC_BIT_BASE = 8'hD8;
    localparam logic [7:0] ACMC_RD_IDLE = 8'h00;
    // ===========================================================
    // Field positions
    localparam int ACMC_DONE_BIT = 7;
    localparam int ACMC_DMA_BIT = 6;
    localparam int ACMC_CONT_BIT = 5;
    localparam int ACMC_SINGLE_BIT = 4;
    localparam int ACMC_CH_LSB = 0;
    localparam int ACMC_CH_W = 4;
    // ===========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        ACMC_IDLE = 2'b00,
        ACMC_CONV = 2'b01,
        ACMC_DMA = 2'b10
    } acmc_state_e;
endpackage

// [hdl/acmc_ctrl.sv]
/*
 Converter mode control register and conversion sequencer.
 Assumes the core bus, the converter, the DMA engine and the core's
 strobe are all logic on clk; no input needs synchronising.
*/
module acmc_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Byte access from the core
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Bit access from the core
    input wire logic [7:0] bit_addr,
    input wire logic bit_wr,
    input wire logic bit_val,
    // Core interrupt logic
    input wire logic int_enable,
    input wire logic isr_vector,
    output logic irq,
    // Converter
    output logic conv_start,
    output logic [acmc_pkg::ACMC_CH_W-1:0] conv_channel,
    input wire logic conv_done,
    // DMA engine
    output logic dma_start,
    input wire logic [acmc_pkg::ACMC_CH_W-1:0] dma_channel_id,
    input wire logic dma_block_done,
    // Address latch strobe
    input wire logic ale_in,
    output logic ale_out
);
    import acmc_pkg::*;

    // ===========================================================
    // Register and sequencer state
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    acmc_state_e state_r, state_nxt;
    logic start_r, start_nxt;
    logic dstart_r, dstart_nxt;
    logic [ACMC_CH_W-1:0] chan_r, chan_nxt;
    logic irq_r, irq_nxt;
    logic ale_r, ale_nxt;
    logic [7:0] sw_val;
    logic conv_end;

    always_comb begin
        // Software view first, hardware events then override
        sw_val = ctrl_r;
        if (sfr_wr && sfr_addr == ACMC_ADDR) begin
            sw_val = sfr_wdata;
        end else if (bit_wr && bit_addr[7:3] == ACMC_BIT_BASE[7:3]) begin
            sw_val[bit_addr[2:0]] = bit_val;
        end
        ctrl_nxt = sw_val;
        state_nxt = state_r;
        start_nxt = 1'b0;
        dstart_nxt = 1'b0;
        chan_nxt = chan_r;
        conv_end = 1'b0;
        if (isr_vector) begin
            ctrl_nxt[ACMC_DONE_BIT] = 1'b0;
        end
        unique case (state_r)
            ACMC_IDLE: begin
                if (sw_val[ACMC_DMA_BIT]) begin
                    dstart_nxt = 1'b1;
                    state_nxt = ACMC_DMA;
                end else if (sw_val[ACMC_SINGLE_BIT]
                             || sw_val[ACMC_CONT_BIT]) begin
                    start_nxt = 1'b1;
                    chan_nxt = sw_val[ACMC_CH_LSB +: ACMC_CH_W];
                    state_nxt = ACMC_CONV;
                end
            end
            ACMC_CONV: begin
                if (conv_done) begin
                    conv_end = 1'b1;
                    ctrl_nxt[ACMC_DONE_BIT] = 1'b1;
                    ctrl_nxt[ACMC_SINGLE_BIT] = 1'b0;
                    state_nxt = ACMC_IDLE;
                    // Back to back restart, settings taken fresh
                    if (sw_val[ACMC_CONT_BIT]
                        && !sw_val[ACMC_DMA_BIT]) begin
                        start_nxt = 1'b1;
                        chan_nxt = sw_val[ACMC_CH_LSB +: ACMC_CH_W];
                        state_nxt = ACMC_CONV;
                    end
                end
            end
            ACMC_DMA: begin
                chan_nxt = dma_channel_id;
                if (dma_block_done) begin
                    ctrl_nxt[ACMC_DONE_BIT] = 1'b1;
                    ctrl_nxt[ACMC_DMA_BIT] = 1'b0;
                    state_nxt = ACMC_IDLE;
                end
            end
            default: state_nxt = ACMC_IDLE;
        endcase
        irq_nxt = ctrl_nxt[ACMC_DONE_BIT] && int_enable;
        // Strobe held low while the DMA bit is set, whatever the sequencer state
        ale_nxt = ctrl_nxt[ACMC_DMA_BIT] ? 1'b0 : ale_in;
        rdata_nxt = (sfr_rd && sfr_addr == ACMC_ADDR) ? ctrl_r
                                                       : ACMC_RD_IDLE;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r <= ACMC_RESET;
            rdata_r <= ACMC_RD_IDLE;
            state_r <= ACMC_IDLE;
            start_r <= 1'b0;
            dstart_r <= 1'b0;
            chan_r <= '0;
            irq_r <= 1'b0;
            ale_r <= 1'b0;
        end else if (ce) begin
            ctrl_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
            state_r <= state_nxt;
            start_r <= start_nxt;
            dstart_r <= dstart_nxt;
            chan_r <= chan_nxt;
            irq_r <= irq_nxt;
            ale_r <= ale_nxt;
        end
    end

    assign sfr_rdata = rdata_r;
    assign irq = irq_r;
    assign conv_start = start_r;
    assign conv_channel = chan_r;
    assign dma_start = dstart_r;
    assign ale_out = ale_r;

    // ===========================================================
    // Checks
    sequence s_single_ends;
        state_r == ACMC_CONV && conv_done && ce;
    endsequence
    sequence s_dma_ends;
        state_r == ACMC_DMA && dma_block_done && ce;
    endsequence

    a_flag_on_done: assert property (@(posedge clk) disable iff (!rst_n)
        (s_single_ends or s_dma_ends) |=> ctrl_r[ACMC_DONE_BIT])
        else $error("done flag not set at end of conversion");
    a_dma_bit_clr: assert property (@(posedge clk) disable iff (!rst_n)
        s_dma_ends |=> !ctrl_r[ACMC_DMA_BIT])
        else $error("dma bit not cleared at block end");
    a_single_clr: assert property (@(posedge clk) disable iff (!rst_n)
        s_single_ends ##0 !sfr_wr ##0 !bit_wr
        |=> !ctrl_r[ACMC_SINGLE_BIT])
        else $error("single bit not cleared at end");
    a_isr_clears: assert property (@(posedge clk) disable iff (!rst_n)
        ce && isr_vector && !conv_done && !dma_block_done
        && !sfr_wr && !bit_wr |=> !ctrl_r[ACMC_DONE_BIT])
        else $error("done flag not cleared on vector");
    a_dma_starts: assert property (@(posedge clk) disable iff (!rst_n)
        ce && state_r == ACMC_IDLE && ctrl_nxt[ACMC_DMA_BIT]
        && sw_val[ACMC_DMA_BIT] |=> dma_start ##1 !dma_start)
        else $error("dma start not pulsed");
    a_ale_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        ce && ctrl_r[ACMC_DMA_BIT] && !dma_block_done && !sfr_wr
        && !bit_wr |=> !ale_out)
        else $error("strobe moved during dma");
    a_cont_restart: assert property (@(posedge clk) disable iff (!rst_n)
        s_single_ends ##0 sw_val[ACMC_CONT_BIT] && !sw_val[ACMC_DMA_BIT]
        |=> conv_start && state_r == ACMC_CONV)
        else $error("continuous mode did not restart");
    a_chan_field: assert property (@(posedge clk) disable iff (!rst_n)
        ce && start_nxt |=> conv_channel
        == $past(sw_val[ACMC_CH_LSB +: ACMC_CH_W]))
        else $error("wrong channel at start");
    a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
        ce ##1 (ctrl_r[ACMC_DONE_BIT] && $past(int_enable))
        |-> irq)
        else $error("interrupt not requested");

    // ===========================================================
    // Register access checks
    sequence s_byte_hit;
        ce && sfr_wr && sfr_addr == ACMC_ADDR;
    endsequence
    sequence s_read_hit;
        ce && sfr_rd && sfr_addr == ACMC_ADDR;
    endsequence
    sequence s_bit0_hit;
        ce && bit_wr && !sfr_wr && bit_addr == ACMC_BIT_BASE;
    endsequence

    // Channel field is never touched by hardware, so a write shows as is
    a_byte_write: assert property (@(posedge clk) disable iff (!rst_n)
        s_byte_hit |=> ctrl_r[ACMC_CH_LSB +: ACMC_CH_W]
        == $past(sfr_wdata[ACMC_CH_LSB +: ACMC_CH_W]))
        else $error("byte write not taken");

    a_bit_write: assert property (@(posedge clk) disable iff (!rst_n)
        s_bit0_hit |=> ctrl_r[ACMC_CH_LSB] == $past(bit_val))
        else $error("bit write not taken");

    a_read_data: assert property (@(posedge clk) disable iff (!rst_n)
        s_read_hit |=> sfr_rdata == $past(ctrl_r))
        else $error("read data wrong");

    // Idle bus reads as zero so a mux of many registers can OR them
    a_read_idle: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !(sfr_rd && sfr_addr == ACMC_ADDR)
        |=> sfr_rdata == ACMC_RD_IDLE)
        else $error("read data not idle");

    // ===========================================================
    // Channel and strobe checks
    a_dma_chan: assert property (@(posedge clk) disable iff (!rst_n)
        ce && state_r == ACMC_DMA
        |=> conv_channel == $past(dma_channel_id))
        else $error("dma channel not followed");

    a_ale_follow: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !ctrl_nxt[ACMC_DMA_BIT]
        |=> ale_out == $past(ale_in))
        else $error("strobe not passed through");
endmodule

// [bench/acmc_conv_model.sv]
/* Converter and DMA engine stand-in for the mode control bench.
   Assumes one-cycle start pulses on clk from the block. */
module acmc_conv_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Start pulses
    input wire logic conv_start,
    input wire logic dma_start,
    // Completion and memory channel id
    output logic conv_done,
    output logic dma_block_done,
    output logic [3:0] dma_channel_id
);
    timeunit 1ns;
    timeprecision 1ns;
    int conv_cnt = 0;
    int dma_cnt = 0;
    initial begin
        conv_done = 1'b0;
        dma_block_done = 1'b0;
        dma_channel_id = 4'h5;
    end
    // ===========================================================
    // Fixed latencies; done pulses last one cycle
    always @(posedge clk) begin
        conv_done <= rst_n && conv_cnt == 1;
        dma_block_done <= rst_n && dma_cnt == 1;
        conv_cnt <= !rst_n ? 0 : conv_start ? 6 : conv_cnt > 0 ? conv_cnt - 1 : 0;
        dma_cnt <= !rst_n ? 0 : dma_start ? 20 : dma_cnt > 0 ? dma_cnt - 1 : 0;
        // Id only valid inside a block, so it churns outside one
        dma_channel_id <= dma_cnt > 0 ? 4'hA : ~dma_channel_id;
    end
endmodule

// [bench/acmc_ctrl_tb.sv]
/* Self-checking bench for the converter mode control block.
   Assumes the converter and DMA engine model in acmc_conv_model. */
module acmc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import acmc_pkg::*;
    logic clk = 0, rst_n = 0, ce = 1, sfr_wr = 0, sfr_rd = 0, bit_wr = 0;
    logic bit_val = 0, int_enable = 1, isr_vector = 0, ale_in = 0;
    logic irq, conv_start, conv_done, dma_start, dma_block_done, ale_out;
    logic [7:0] sfr_addr = 0, sfr_wdata = 0, bit_addr = 0, sfr_rdata;
    logic [ACMC_CH_W-1:0] conv_channel, dma_channel_id;
    int err_count = 0, n_checks = 0;
    logic a;
    acmc_ctrl acmc_ctrl_i (.clk(clk), .rst_n(rst_n), .ce(ce),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bit_addr(bit_addr),
        .bit_wr(bit_wr), .bit_val(bit_val), .int_enable(int_enable),
        .isr_vector(isr_vector), .irq(irq), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_done(conv_done),
        .dma_start(dma_start), .dma_channel_id(dma_channel_id),
        .dma_block_done(dma_block_done), .ale_in(ale_in), .ale_out(ale_out));
    acmc_conv_model acmc_conv_model_i (.clk(clk), .rst_n(rst_n),
        .conv_start(conv_start), .dma_start(dma_start), .conv_done(conv_done),
        .dma_block_done(dma_block_done), .dma_channel_id(dma_channel_id));
    always #10 clk = ~clk;
    always @(posedge clk) ale_in <= ~ale_in;
    // ===========================================================
    // Shared tasks
    task finish_test;
        if (err_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
            err_count++;
        end
    endtask
    task rd_chk(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge clk) {sfr_rd, sfr_addr} <= {1'b1, ad};
        @(posedge clk) sfr_rd <= 1'b0;
        #1 check(sfr_rdata, exp);
    endtask
    task bw(input logic [7:0] d);
        @(posedge clk) {sfr_wr, sfr_addr, sfr_wdata} <= {1'b1, 8'hD8, d};
        @(posedge clk) sfr_wr <= 1'b0;
    endtask
    task bitw(input logic [2:0] pos, input logic v);
        @(posedge clk) {bit_wr, bit_addr, bit_val} <= {1'b1, 8'hD8 + pos, v};
        @(posedge clk) bit_wr <= 1'b0;
    endtask
    // Bounded wait; a hang counts as a mismatch
    task wait_on(input int sel);
        logic [4:0] hit;
        for (int i = 0; i < 100; i++) begin
            #1;
            hit = {dma_block_done, conv_done, irq, dma_start, conv_start};
            if (hit[sel]) return;
            @(posedge clk);
        end
        err_count++;
        finish_test();
    endtask
    // ===========================================================
    // Scenarios
    task t_single;
        bw(8'h15);
        wait_on(0);
        check(conv_channel, 8'h05);
        wait_on(2);
        rd_chk(8'hD8, 8'h85);
        @(posedge clk) isr_vector <= 1'b1;
        @(posedge clk) isr_vector <= 1'b0;
        #1 check(irq, 8'h00);
        rd_chk(8'hD8, 8'h05);
    endtask
    task t_cont;
        bitw(3'd5, 1'b1);
        wait_on(0);
        bw(8'h23);
        wait_on(3);
        @(posedge clk);
        #1 check(conv_start, 8'h01);
        check(conv_channel, 8'h03);
        bitw(3'd5, 1'b0);
        wait_on(3);
        bw(8'h00);
        rd_chk(8'hD8, 8'h00);
    endtask
    task t_dma;
        bw(8'h40);
        wait_on(1);
        repeat (4) begin
            @(posedge clk);
            #1 check(ale_out, 8'h00);
        end
        check(conv_channel, 8'h0A);
        wait_on(4);
        rd_chk(8'hD8, 8'h80);
        a = ale_out;
        @(posedge clk);
        #1 check(ale_out, {7'h0, ~a});
    endtask
    task t_hold;
        @(posedge clk) ce <= 1'b0;
        bw(8'h15);
        ce <= 1'b1;
        rd_chk(8'hD8, 8'h80);
        @(posedge clk) int_enable <= 1'b0;
        @(posedge clk);
        #1 check(irq, 8'h00);
        @(posedge clk) int_enable <= 1'b1;
        bitw(3'd0, 1'b1);
        rd_chk(8'hD8, 8'h81);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(8'hD8, 8'h00);
        rd_chk(8'hD9, 8'h00);
        t_single();
        t_cont();
        t_dma();
        t_hold();
        finish_test();
    end
endmodule
